/* rtl/pfd_defines.vh */
// Constants for the loop-2 feedback divider and lock detector block
`ifndef PFD_DEFINES_VH
`define PFD_DEFINES_VH
`define PFD_OFS_CTRL 4'h0
`define PFD_OFS_NDIV 4'h1
`define PFD_OFS_NCAL 4'h2
`define PFD_OFS_WIN 4'h3
`define PFD_OFS_CNT1 4'h4
`define PFD_OFS_CNT2 4'h5
`define PFD_OFS_CNTH 4'h6
`define PFD_OFS_STAT 4'h7
`define PFD_AW 4
`define PFD_PRE_W 4
`define PFD_PRE_MIN 4'h2
`define PFD_PRE_MAX 4'h8
`define PFD_N_W 19
`define PFD_N_MIN 19'h00001
`define PFD_N_MAX 19'h403e7
`define PFD_PD_W 3
`define PFD_WIN_W 8
`define PFD_CNT_W 14
`define PFD_CTRL_PRE_LSB 0
`define PFD_CTRL_PD_LSB 4
`define PFD_CTRL_PATH 8
`define PFD_CTRL_EXT 9
`define PFD_CTRL_CAL 10
`define PFD_CTRL_HENTER 11
`define PFD_RST_PRE 4'h2
`define PFD_RST_PD 3'h2
`define PFD_RST_N 19'h00019
`define PFD_RST_WIN 8'h04
`define PFD_RST_CNT 14'h0400
`define PFD_DET_N 3
`endif

/* rtl/pfd_top.v */
// Loop-2 feedback divider chain and digital lock detector with AHB-Lite registers
//
// Behaviour
// - Prescaler accepts ratios two through eight
// - Feedback counter accepts ratios one to 263143
// - Normal feedback divide is prescaler times counter, optional post-divider
// - Calibration uses calibration counter, optional post-divider
// - External oscillator ignores calibration counter value
// - Three lock events with own count; holdover exit shares the loop-1 window
// - Lock after count cycles inside window
// - Window violation resets running count
// - Loop lock event asserts loop lock indication
// - Holdover exit event leaves holdover mode
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`include "pfd_defines.vh"

module pfd_top (
  input wire CORE_CLK,
  input wire RESETN,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  input wire OSC_TICK,
  input wire LOOP1_REF_EDGE,
  input wire LOOP1_FB_EDGE,
  input wire LOOP2_REF_EDGE,
  output reg LOOP2_FB_EDGE,
  output reg LOOP1_LOCKED,
  output reg LOOP2_LOCKED,
  output reg HOLDOVER_MODE
);
  // Bus slave: zero wait state, always OKAY
  reg dph_wr_ff;
  reg dph_rd_ff;
  reg [`PFD_AW-1:0] dph_idx_ff;
  reg [`PFD_PRE_W-1:0] prescaler_ff;
  reg [`PFD_PD_W-1:0] post_div_ff;
  reg path_sel_ff;
  reg ext_osc_ff;
  reg cal_ff;
  reg [`PFD_N_W-1:0] fb_cnt_cfg_ff;
  reg [`PFD_N_W-1:0] cal_cnt_cfg_ff;
  reg [`PFD_WIN_W-1:0] win1_ff;
  reg [`PFD_WIN_W-1:0] win2_ff;
  reg [`PFD_CNT_W-1:0] lcnt1_ff;
  reg [`PFD_CNT_W-1:0] lcnt2_ff;
  reg [`PFD_CNT_W-1:0] hcnt_ff;
  wire addr_ok;
  wire wr_en;
  wire hold_enter;
  // No wait states: every register is a flop, so reads never stall
  assign HREADYOUT = 1'b1;
  // No error response; unmapped words are simply ignored
  assign HRESP = 1'b0;
  // Upper address bits must be zero, low bits word aligned
  assign addr_ok = (HADDR[31:5] == 27'h0000000) && (HADDR[1:0] == 2'h0);
  assign wr_en = dph_wr_ff;
  // Write-one strobe, not stored, so it always reads back zero
  assign hold_enter = wr_en && (dph_idx_ff == `PFD_OFS_CTRL) && HWDATA[`PFD_CTRL_HENTER];

  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      dph_wr_ff <= 1'b0;
      dph_rd_ff <= 1'b0;
      dph_idx_ff <= {`PFD_AW{1'b0}};
    end else begin
      dph_wr_ff <= HSEL && HREADY && HTRANS[1] && HWRITE && addr_ok;
      dph_rd_ff <= HSEL && HREADY && HTRANS[1] && !HWRITE && addr_ok;
      dph_idx_ff <= {1'b0, HADDR[4:2]};
    end
  end

  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      prescaler_ff <= `PFD_RST_PRE;
      post_div_ff <= `PFD_RST_PD;
      path_sel_ff <= 1'b0;
      ext_osc_ff <= 1'b0;
      cal_ff <= 1'b0;
      fb_cnt_cfg_ff <= `PFD_RST_N;
      cal_cnt_cfg_ff <= `PFD_RST_N;
      win1_ff <= `PFD_RST_WIN;
      win2_ff <= `PFD_RST_WIN;
      lcnt1_ff <= `PFD_RST_CNT;
      lcnt2_ff <= `PFD_RST_CNT;
      hcnt_ff <= `PFD_RST_CNT;
    end else if (wr_en) begin
      case (dph_idx_ff)
        `PFD_OFS_CTRL: begin
          prescaler_ff <= HWDATA[`PFD_CTRL_PRE_LSB +: `PFD_PRE_W];
          post_div_ff <= HWDATA[`PFD_CTRL_PD_LSB +: `PFD_PD_W];
          path_sel_ff <= HWDATA[`PFD_CTRL_PATH];
          ext_osc_ff <= HWDATA[`PFD_CTRL_EXT];
          cal_ff <= HWDATA[`PFD_CTRL_CAL];
        end
        `PFD_OFS_NDIV: fb_cnt_cfg_ff <= HWDATA[`PFD_N_W-1:0];
        `PFD_OFS_NCAL: cal_cnt_cfg_ff <= HWDATA[`PFD_N_W-1:0];
        `PFD_OFS_WIN: begin
          win1_ff <= HWDATA[`PFD_WIN_W-1:0];
          win2_ff <= HWDATA[2*`PFD_WIN_W-1:`PFD_WIN_W];
        end
        `PFD_OFS_CNT1: lcnt1_ff <= HWDATA[`PFD_CNT_W-1:0];
        `PFD_OFS_CNT2: lcnt2_ff <= HWDATA[`PFD_CNT_W-1:0];
        `PFD_OFS_CNTH: hcnt_ff <= HWDATA[`PFD_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux over registered state; unmapped words read zero
  always @* begin
    HRDATA = 32'h00000000;
    if (dph_rd_ff) begin
      case (dph_idx_ff)
        `PFD_OFS_CTRL: HRDATA = {21'h000000, cal_ff, ext_osc_ff, path_sel_ff, 1'b0,
                                 post_div_ff, prescaler_ff};
        `PFD_OFS_NDIV: HRDATA = {13'h0000, fb_cnt_cfg_ff};
        `PFD_OFS_NCAL: HRDATA = {13'h0000, cal_cnt_cfg_ff};
        `PFD_OFS_WIN: HRDATA = {16'h0000, win2_ff, win1_ff};
        `PFD_OFS_CNT1: HRDATA = {18'h00000, lcnt1_ff};
        `PFD_OFS_CNT2: HRDATA = {18'h00000, lcnt2_ff};
        `PFD_OFS_CNTH: HRDATA = {18'h00000, hcnt_ff};
        `PFD_OFS_STAT: HRDATA = {29'h00000000, HOLDOVER_MODE, LOOP2_LOCKED, LOOP1_LOCKED};
        default: HRDATA = 32'h00000000;
      endcase
    end
  end

  // Feedback divider chain: optional post-divider, prescaler, counter in series
  wire [`PFD_PRE_W-1:0] pre_ratio;
  wire [`PFD_N_W-1:0] n_sel;
  wire [`PFD_N_W-1:0] n_ratio;
  wire [`PFD_PD_W-1:0] pd_ratio;
  wire use_cal;
  wire pd_tick;
  wire pre_tick;
  wire n_tick;
  reg [`PFD_PD_W-1:0] pd_cnt_ff;
  reg [`PFD_PRE_W-1:0] pre_cnt_ff;
  reg [`PFD_N_W-1:0] n_cnt_ff;
  // Out-of-range settings are clamped rather than stalling the loop
  assign pre_ratio = (prescaler_ff < `PFD_PRE_MIN) ? `PFD_PRE_MIN :
                     (prescaler_ff > `PFD_PRE_MAX) ? `PFD_PRE_MAX : prescaler_ff;
  // External oscillator never takes the calibration count
  assign use_cal = cal_ff && !ext_osc_ff;
  assign n_sel = use_cal ? cal_cnt_cfg_ff : fb_cnt_cfg_ff;
  assign n_ratio = (n_sel < `PFD_N_MIN) ? `PFD_N_MIN :
                   (n_sel > `PFD_N_MAX) ? `PFD_N_MAX : n_sel;
  assign pd_ratio = (post_div_ff == {`PFD_PD_W{1'b0}}) ? {{(`PFD_PD_W-1){1'b0}}, 1'b1} :
                    post_div_ff;
  assign pd_tick = path_sel_ff ? (OSC_TICK && (pd_cnt_ff >= pd_ratio - 1'b1)) : OSC_TICK;
  assign pre_tick = pd_tick && (pre_cnt_ff >= pre_ratio - 1'b1);
  assign n_tick = pre_tick && (n_cnt_ff >= n_ratio - 1'b1);

  // Greater-or-equal compares let a ratio lowered mid-count end the
  // current period at once instead of wrapping the full counter
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pd_cnt_ff <= {`PFD_PD_W{1'b0}};
      pre_cnt_ff <= {`PFD_PRE_W{1'b0}};
      n_cnt_ff <= {`PFD_N_W{1'b0}};
      LOOP2_FB_EDGE <= 1'b0;
    end else begin
      if (OSC_TICK) begin
        pd_cnt_ff <= (!path_sel_ff || pd_tick) ? {`PFD_PD_W{1'b0}} : pd_cnt_ff + 1'b1;
      end
      if (pd_tick) begin
        pre_cnt_ff <= pre_tick ? {`PFD_PRE_W{1'b0}} : pre_cnt_ff + 1'b1;
      end
      if (pre_tick) begin
        n_cnt_ff <= n_tick ? {`PFD_N_W{1'b0}} : n_cnt_ff + 1'b1;
      end
      LOOP2_FB_EDGE <= n_tick;
    end
  end

  // Lock detectors: 0 loop-1 lock, 1 loop-2 lock, 2 holdover exit
  wire [`PFD_DET_N-1:0] det_ref;
  wire [`PFD_DET_N-1:0] det_fb;
  wire [`PFD_DET_N*`PFD_WIN_W-1:0] det_win;
  wire [`PFD_DET_N*`PFD_CNT_W-1:0] det_tgt;
  wire [`PFD_DET_N-1:0] det_lock;
  // Holdover detector shares loop-1 edges and window, own count
  assign det_ref = {LOOP1_REF_EDGE, LOOP2_REF_EDGE, LOOP1_REF_EDGE};
  assign det_fb = {LOOP1_FB_EDGE, LOOP2_FB_EDGE, LOOP1_FB_EDGE};
  assign det_win = {win1_ff, win2_ff, win1_ff};
  assign det_tgt = {hcnt_ff, lcnt2_ff, lcnt1_ff};

  genvar gi;
  generate
    for (gi = 0; gi < `PFD_DET_N; gi = gi + 1) begin : g_det
      reg pend_ff;
      reg src_fb_ff;
      reg [`PFD_WIN_W-1:0] tmr_ff;
      reg [`PFD_CNT_W-1:0] cnt_ff;
      reg nxt_pend;
      reg nxt_src_fb;
      reg [`PFD_WIN_W-1:0] nxt_tmr;
      reg [`PFD_CNT_W-1:0] nxt_cnt;
      reg good;
      reg bad;
      wire r;
      wire f;
      wire [`PFD_WIN_W-1:0] win;
      wire [`PFD_CNT_W-1:0] tgt;
      wire [`PFD_WIN_W:0] elapsed;
      assign r = det_ref[gi];
      assign f = det_fb[gi];
      assign win = det_win[gi*`PFD_WIN_W +: `PFD_WIN_W];
      assign tgt = det_tgt[gi*`PFD_CNT_W +: `PFD_CNT_W];
      // One extra bit so the timer cannot wrap at a full window
      assign elapsed = {1'b0, tmr_ff} + 1'b1;
      // Target of zero reads as locked straight away
      assign det_lock[gi] = (cnt_ff >= tgt);
      always @* begin
        nxt_pend = pend_ff;
        nxt_src_fb = src_fb_ff;
        nxt_tmr = tmr_ff;
        good = 1'b0;
        bad = 1'b0;
        if (r && f) begin
          // Coincident edges: zero error, only a zero window rejects it
          good = (win != {`PFD_WIN_W{1'b0}});
          bad = !good;
          nxt_pend = 1'b0;
        end else if (!pend_ff) begin
          if (r || f) begin
            nxt_pend = 1'b1;
            nxt_src_fb = f;
            nxt_tmr = {`PFD_WIN_W{1'b0}};
          end
        end else if ((r && src_fb_ff) || (f && !src_fb_ff)) begin
          good = (elapsed < {1'b0, win});
          bad = !good;
          nxt_pend = 1'b0;
        end else if (r || f) begin
          // Same edge twice: its partner never arrived in this cycle
          bad = 1'b1;
          nxt_src_fb = f;
          nxt_tmr = {`PFD_WIN_W{1'b0}};
        end else if (elapsed >= {1'b0, win}) begin
          bad = 1'b1;
          nxt_pend = 1'b0;
        end else begin
          nxt_tmr = elapsed[`PFD_WIN_W-1:0];
        end
        nxt_cnt = cnt_ff;
        if (bad) begin
          nxt_cnt = {`PFD_CNT_W{1'b0}};
        end else if (good && (cnt_ff < tgt)) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      always @(posedge CORE_CLK) begin
        if (!RESETN) begin
          pend_ff <= 1'b0;
          src_fb_ff <= 1'b0;
          tmr_ff <= {`PFD_WIN_W{1'b0}};
          cnt_ff <= {`PFD_CNT_W{1'b0}};
        end else begin
          pend_ff <= nxt_pend;
          src_fb_ff <= nxt_src_fb;
          tmr_ff <= nxt_tmr;
          cnt_ff <= nxt_cnt;
        end
      end
    end
  endgenerate

  // Holdover exit acts on the rising edge of the third detector's lock
  // Limitation: a held lock cannot exit again until it is lost first
  reg hexit_prev_ff;
  wire hexit_event;
  assign hexit_event = det_lock[2] && !hexit_prev_ff;
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      LOOP1_LOCKED <= 1'b0;
      LOOP2_LOCKED <= 1'b0;
      HOLDOVER_MODE <= 1'b0;
      hexit_prev_ff <= 1'b0;
    end else begin
      LOOP1_LOCKED <= det_lock[0];
      LOOP2_LOCKED <= det_lock[1];
      hexit_prev_ff <= det_lock[2];
      // Software entry wins over a simultaneous exit
      if (hold_enter) begin
        HOLDOVER_MODE <= 1'b1;
      end else if (hexit_event) begin
        HOLDOVER_MODE <= 1'b0;
      end
    end
  end
endmodule

/* testbench/pfd_top_properties.sv */
// Checker for the divider and lock detector ports
`timescale 1ns/100ps
module pfd_chk (
  input wire CORE_CLK,
  input wire RESETN,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [31:0] HRDATA,
  input wire OSC_TICK,
  input wire LOOP1_REF_EDGE,
  input wire LOOP1_FB_EDGE,
  input wire LOOP2_REF_EDGE,
  input wire LOOP2_FB_EDGE,
  input wire LOOP1_LOCKED,
  input wire LOOP2_LOCKED,
  input wire HOLDOVER_MODE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  wire wr = HSEL && HREADY && HTRANS[1] && HWRITE;
  wire e1 = LOOP1_REF_EDGE || LOOP1_FB_EDGE;
  wire rs = HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'h0000001c;
  wire [2:0] st = {HOLDOVER_MODE, LOOP2_LOCKED, LOOP1_LOCKED};
  // Quiet status around the read, so a late flop cannot race the mux
  sequence s_rd_st;
    rs ##1 $stable(st) ##1 $stable(st);
  endsequence
  a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not okay");
  a_fb_gap: assert property (LOOP2_FB_EDGE |=> !LOOP2_FB_EDGE) else $error("fb twice");
  a_fb_tick: assert property (LOOP2_FB_EDGE |-> $past(OSC_TICK)) else $error("no tick");
  a_l1_rise: assert property ($rose(LOOP1_LOCKED) |-> $past(e1, 2) || $past(wr, 3))
    else $error("loop1 lock without pair");
  a_l2_rise: assert property ($rose(LOOP2_LOCKED) |->
    $past(LOOP2_REF_EDGE || LOOP2_FB_EDGE, 2) || $past(LOOP2_FB_EDGE) || $past(wr, 3))
    else $error("loop2 lock without pair");
  a_ho_enter: assert property ($rose(HOLDOVER_MODE) |-> $past(wr, 2))
    else $error("holdover without write");
  a_ho_exit: assert property ($fell(HOLDOVER_MODE) |-> $past(e1, 2) || $past(wr, 3))
    else $error("holdover left without pair");
  a_stat_map: assert property (s_rd_st |-> $past(HRDATA[2:0]) == $past(st))
    else $error("status read wrong");
endmodule
bind pfd_top pfd_chk chk_u (.*);

/* testbench/pfd_top_tb_top.sv */
// Bench for the feedback divider chain and lock detector
`timescale 1ns/100ps
module pfd_top_tb_top;
  reg clk = 0, rstn = 0, tick = 0, r2 = 0, fol = 0;
  reg [3:0] bus = 4'h0;
  reg [1:0] e1 = 2'h0;
  reg [31:0] ad = 32'h0, wd = 32'h0, d;
  wire rdy, fb2, l1, l2, ho;
  wire [31:0] rd;
  integer n_fail = 0, samples_checked = 0, i, n;
  localparam logic [31:0] rst_vals [0:8] = '{32'h22, 32'h19, 32'h19, 32'h404, 32'h400,
    32'h400, 32'h400, 32'h0, 32'h0};
  localparam logic [63:0] cases [0:6] = '{64'h0022_0001_0009_0002, 64'h0028_0003_0009_0018,
    64'h0132_0002_0009_000c, 64'h0422_0005_0004_0008, 64'h0522_0005_0003_000c,
    64'h0622_0005_0004_000a, 64'h002f_0001_0009_0008};
  always #2 clk = ~clk;
  // Far edge trails feedback by one cycle, inside any window above one
  always @(posedge clk) r2 <= fol & fb2;
  pfd_top dut_u (.CORE_CLK(clk), .RESETN(rstn), .HSEL(bus[3]), .HADDR(ad), .HTRANS(bus[1:0]),
    .HWRITE(bus[2]), .HSIZE(3'h2), .HWDATA(wd), .HREADY(rdy), .HREADYOUT(rdy), .HRESP(),
    .HRDATA(rd), .OSC_TICK(tick), .LOOP1_REF_EDGE(e1[1]), .LOOP1_FB_EDGE(e1[0]),
    .LOOP2_REF_EDGE(r2), .LOOP2_FB_EDGE(fb2), .LOOP1_LOCKED(l1), .LOOP2_LOCKED(l2),
    .HOLDOVER_MODE(ho));
  task give_verdict;
    begin
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task wf(input integer w, output integer c);
    begin
      @(posedge clk);
      for (c = 0; (w == 0 ? rdy : w == 1 ? fb2 : l2) !== 1'b1; c = c + 1) begin
        if (c > 300) begin
          n_fail = n_fail + 1;
          give_verdict;
        end
        @(posedge clk);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] v);
    integer k;
    begin
      bus <= {1'b1, w, 2'h2};
      ad <= a;
      wf(0, k);
      bus <= 4'h0;
      wd <= v;
      wf(0, k);
      d = rd;
    end
  endtask
  task pr(input [1:0] v);
    begin
      e1 <= v;
      @(posedge clk);
      e1 <= 2'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 9; i = i + 1) begin
      xfer(0, 4 * i, 0);
      chk(d, rst_vals[i]);
    end
    tick <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      xfer(1, 0, cases[i][63:48]);
      xfer(1, 4, cases[i][47:32]);
      xfer(1, 8, cases[i][31:16]);
      wf(1, n);
      wf(1, n);
      chk(n + 1, cases[i][15:0]);
    end
    xfer(1, 32'h10, 3);
    for (i = 0; i < 4; i = i + 1) begin
      pr(2'h3);
      chk(l1, i > 1);
    end
    pr(2'h2);
    repeat (5) @(posedge clk);
    chk(l1, 0);
    xfer(1, 32'h18, 2);
    xfer(1, 0, 32'h822);
    repeat (2) @(posedge clk);
    chk(ho, 1);
    pr(2'h3);
    pr(2'h3);
    chk(ho, 0);
    xfer(1, 4, 2);
    xfer(1, 32'h14, 5);
    fol <= 1'b1;
    wf(2, n);
    chk(n > 14, 1);
    xfer(0, 32'h1c, 0);
    chk(d, 32'h2);
    fol <= 1'b0;
    repeat (12) @(posedge clk);
    chk(l2, 0);
    give_verdict;
  end
endmodule
